/* File: pkg/pps_pkg.sv */
// Constants shared by the point-of-load protection supervisor.
// Assumes a 25 MHz APB clock and comparator inputs from the analog front end.
package pps_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_HZ = 25_000_000;
  localparam int MS_CYCLES = CLK_HZ / 1000;
  localparam logic [7:0] RETRY_MS = 8'h82;        // 130 ms between restarts.
  localparam logic [7:0] PG_DELAY_MAX_MS = 8'h96; // 150 ms release delay.

  // Comparator set points in the analog front end, for reference.
  localparam int TEMP_WARN_ON_C = 120;
  localparam int TEMP_WARN_OFF_C = 117;
  localparam int TEMP_RESTART_C = 110;
  localparam int TRACK_ERR_MV = 250;

  // ==========================================================================
  // Register byte addresses
  // ==========================================================================
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_THR = 8'h04;
  localparam logic [7:0] ADDR_PROT = 8'h0c;
  localparam logic [7:0] ADDR_STAT = 8'h10;
  localparam logic [7:0] ADDR_STATE = 8'h14;
  localparam logic [7:0] ADDR_CLS = 8'h20;

  // ==========================================================================
  // Reset values and field positions
  // ==========================================================================
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam int CTRL_EN = 0;
  localparam int CTRL_PG_RAMP = 1;
  localparam int CTRL_UV_CRIT = 2;
  localparam int CTRL_OT_CRIT = 3;
  localparam logic [5:0] THR_RST = 6'h08;
  localparam int THR_PG_HI105 = 5;
  localparam int THR_PG_LO95 = 4;
  localparam logic [7:0] PROT_RST = 8'h43;
  localparam int PROT_TRE = 7;
  localparam int PROT_TRC = 5;
  localparam int PROT_OTC = 4;
  localparam int PROT_OCC = 3;
  localparam int PROT_UVC = 2;
  localparam int PROT_OVC = 1;
  localparam logic [7:0] CLS_RST = 8'h1b;
  localparam int CLS_TCE = 4;
  localparam logic [7:0] CLS_LIMIT_MAX = 8'h0b;
  localparam logic [6:0] STAT_RST = 7'h7e;
  localparam int ST_PG = 0;
  localparam int ST_TW = 1;
  localparam int ST_OC = 2;
  localparam int ST_UV = 3;
  localparam int ST_OT = 4;
  localparam int ST_TR = 5;
  localparam int ST_OV = 6;

  // Synchronised comparator vector width and reset value.
  localparam int NSYNC = 16;
  localparam logic [NSYNC-1:0] SYNC_RST = 16'h8000;

  typedef enum logic [1:0] {
    PPS_OFF = 2'b00,
    PPS_RUN = 2'b01,
    PPS_FAULT = 2'b10
  } pps_state_t;

endpackage

/* File: hdl/pps_supervisor.sv */
// Protection and supervision logic of a point-of-load converter, with an
// APB register file. Assumes analog comparators report each threshold as a
// level, and that a separate PWM controller obeys the switch commands.
//
// Operation
// - Warnings only set status and pins; they never stop the converter.
// - Temperature above 120 C raises the temperature warning and clears its status bit.
// - Warning clears only below 117 C, giving hysteresis.
// - Good pin driven low whenever output lies outside the good window.
// - Upper good threshold selects 105 or 110 percent of setpoint.
// - Lower good threshold selects 90 or 95 percent of setpoint.
// - Good check armed at steady state; release delayed 0 to 150 ms.
// - Good check stays armed across margin moves; thresholds scale with setpoint.
// - Window violation pulls the good pin low and writes 0 in status.
// - Re-entering the window releases the pin and sets status good.
// - External low on the good pin counts as a good warning.
// - Option: good pin drops at turn-off command or at ramp-down start.
// - Any fault turns off; undervoltage and overtemperature style is programmable.
// - Overcurrent above prebias clears its bit and opens both switches.
// - A bit enables temperature compensation of the overcurrent threshold.
// - Undervoltage in steady state without overcurrent clears bit, ramps down.
// - Overtemperature always armed; above 120 C clears bit, ramps down.
// - Non-latching overtemperature restarts once below 110 C.
// - Ramp-up tracking error over 250 mV clears bit, opens both switches.
// - Tracking protection is enabled by a protection configuration bit, clear at reset.
// - Limits follow margining; tracking ends at good and re-arms only at a restart.
// - Overvoltage above prebias clears bit, opens high side, closes low side.
// - Overvoltage threshold 110 to 130 percent, floor 0.5 V, 0.25 V margin.
// - Non-latching faults retry every 130 ms until the cause is gone.
//
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps

module pps_supervisor #(
  parameter int MS_CYCLES = pps_pkg::MS_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic temp_above_120,
  input wire logic temp_below_117,
  input wire logic temp_below_110,
  input wire logic vout_above_105,
  input wire logic vout_above_110,
  input wire logic vout_below_90,
  input wire logic vout_below_95,
  input wire logic vout_above_prebias,
  input wire logic vout_steady,
  input wire logic vout_ramping_up,
  input wire logic vout_ramping_down,
  input wire logic oc_trip,
  input wire logic uv_trip,
  input wire logic ov_trip,
  input wire logic track_err,
  input wire logic output_good_in,
  output logic output_good_out,
  output logic output_good_oe,
  output logic temp_warning_flag,
  output logic pwm_run,
  output logic seq_rampdown,
  output logic hs_force_off,
  output logic ls_force_off,
  output logic ls_force_on,
  output logic oc_temp_comp_en,
  output logic [3:0] oc_limit_sel,
  output logic [1:0] ov_level_sel,
  output logic [1:0] uv_level_sel
);

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Saturate a programmed value at its documented maximum.
  function automatic logic [7:0] clamp8(input logic [7:0] v,
                                        input logic [7:0] max);
    clamp8 = (v > max) ? max : v;
  endfunction

  // ==========================================================================
  // Input synchronisers
  // ==========================================================================
  logic [pps_pkg::NSYNC-1:0] sync1_r;
  logic [pps_pkg::NSYNC-1:0] sync2_r;
  logic [pps_pkg::NSYNC-1:0] raw_in;

  assign raw_in = {output_good_in, track_err, ov_trip, uv_trip, oc_trip,
                   vout_ramping_down, vout_ramping_up, vout_steady,
                   vout_above_prebias, vout_below_95, vout_below_90,
                   vout_above_110, vout_above_105, temp_below_110,
                   temp_below_117, temp_above_120};

  // Two stages; only the second stage feeds any logic.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= pps_pkg::SYNC_RST;
      sync2_r <= pps_pkg::SYNC_RST;
    end else begin
      sync1_r <= raw_in;
      sync2_r <= sync1_r;
    end
  end

  logic s_hot, s_cool117, s_cool110, s_hi105, s_hi110, s_lo90, s_lo95;
  logic s_prebias, s_steady, s_ramp_up, s_ramp_down;
  logic s_oc, s_uv, s_ov, s_trk, s_pin;
  assign {s_pin, s_trk, s_ov, s_uv, s_oc, s_ramp_down, s_ramp_up, s_steady,
          s_prebias, s_lo95, s_lo90, s_hi110, s_hi105, s_cool110, s_cool117,
          s_hot} = sync2_r;

  // ==========================================================================
  // Register file
  // ==========================================================================
  logic [15:0] ctrl_r;
  logic [5:0] thr_r;
  logic [7:0] prot_r;
  logic [7:0] cls_r;
  logic [6:0] stat_r;
  logic [6:0] stat_nxt;
  pps_pkg::pps_state_t state_r;
  logic wr_en, rd_en, addr_ok;
  logic [7:0] cls_lim;
  logic [6:0] hw_clear;
  logic tw_r;
  logic pg_good_r;

  assign addr_ok = (paddr == pps_pkg::ADDR_CTRL) ||
                   (paddr == pps_pkg::ADDR_THR) ||
                   (paddr == pps_pkg::ADDR_PROT) ||
                   (paddr == pps_pkg::ADDR_STAT) ||
                   (paddr == pps_pkg::ADDR_STATE) ||
                   (paddr == pps_pkg::ADDR_CLS);
  assign wr_en = psel && penable && pready && pwrite && addr_ok;
  assign rd_en = psel && penable && !pready && !pwrite;
  // The limit field saturates before it is stored in the low nibble.
  assign cls_lim = clamp8({4'h0, pwdata[3:0]}, pps_pkg::CLS_LIMIT_MAX);

  // One wait state: pready rises in the second access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !addr_ok;
    end
  end

  // Read data is captured with pready so it stands in the completing cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      case (paddr)
        pps_pkg::ADDR_CTRL: prdata <= {16'h0000, ctrl_r};
        pps_pkg::ADDR_THR: prdata <= {26'h0000000, thr_r};
        pps_pkg::ADDR_PROT: prdata <= {24'h000000, prot_r};
        pps_pkg::ADDR_STAT: prdata <= {25'h0000000, stat_r};
        pps_pkg::ADDR_STATE: prdata <= {24'h000000, hs_force_off,
                                        ls_force_on, seq_rampdown,
                                        pg_good_r, tw_r, 1'b0, state_r};
        pps_pkg::ADDR_CLS: prdata <= {24'h000000, cls_r};
        default: prdata <= 32'h0000_0000;
      endcase
    end else begin
      prdata <= 32'h0000_0000;
    end
  end

  // Configuration registers. Window and level thresholds only change while the PWM is off,
  // so those comparators never see a setting move under a running output; CLS writes always land.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= pps_pkg::CTRL_RST;
      thr_r <= pps_pkg::THR_RST;
      prot_r <= pps_pkg::PROT_RST;
      cls_r <= pps_pkg::CLS_RST;
    end else if (wr_en) begin
      case (paddr)
        pps_pkg::ADDR_CTRL: ctrl_r <= {clamp8(pwdata[15:8],
                                       pps_pkg::PG_DELAY_MAX_MS),
                                       4'h0, pwdata[3:0]};
        pps_pkg::ADDR_THR: if (state_r != pps_pkg::PPS_RUN)
          thr_r <= pwdata[5:0];
        pps_pkg::ADDR_PROT: prot_r <= pwdata[7:0];
        pps_pkg::ADDR_CLS: cls_r <= {pwdata[7:4], cls_lim[3:0]};
        default: ;
      endcase
    end
  end

  // Analog threshold selections come straight from configuration flops.
  assign oc_temp_comp_en = cls_r[pps_pkg::CLS_TCE];
  assign oc_limit_sel = cls_r[3:0];
  assign ov_level_sel = thr_r[3:2];
  assign uv_level_sel = thr_r[1:0];

  // ==========================================================================
  // Millisecond tick
  // ==========================================================================
  logic [31:0] ms_div_r;
  logic ms_tick;
  assign ms_tick = (ms_div_r == 32'(MS_CYCLES - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_div_r <= 32'h0000_0000;
    end else begin
      ms_div_r <= ms_tick ? 32'h0000_0000 : ms_div_r + 32'h0000_0001;
    end
  end

  // ==========================================================================
  // Temperature warning
  // ==========================================================================
  // Hysteresis: set above the high point, withdrawn only below the low one.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tw_r <= 1'b0;
    end else if (s_hot) begin
      tw_r <= 1'b1;
    end else if (s_cool117) begin
      tw_r <= 1'b0;
    end
  end

  assign temp_warning_flag = tw_r;

  // ==========================================================================
  // Output good window
  // ==========================================================================
  logic pg_armed_r;
  logic pg_delay_done_r;
  logic [7:0] pg_cnt_r;
  logic pg_drop;
  logic pg_viol;

  // Comparators scale with the live setpoint, so margining needs no action.
  assign pg_viol = (thr_r[pps_pkg::THR_PG_HI105] ? s_hi105 : s_hi110) ||
                   (thr_r[pps_pkg::THR_PG_LO95] ? s_lo95 : s_lo90);
  assign pg_drop = !ctrl_r[pps_pkg::CTRL_EN] &&
                   (!ctrl_r[pps_pkg::CTRL_PG_RAMP] || s_ramp_down);

  // Arming starts at steady state and survives margin moves until turn-off or a fault.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pg_armed_r <= 1'b0;
    end else if (state_r == pps_pkg::PPS_FAULT || pg_drop) begin
      pg_armed_r <= 1'b0;
    end else if (state_r == pps_pkg::PPS_RUN && s_steady) begin
      pg_armed_r <= 1'b1;
    end
  end

  // The release delay runs once per arming, in whole milliseconds.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pg_cnt_r <= 8'h00;
      pg_delay_done_r <= 1'b0;
    end else if (!pg_armed_r) begin
      pg_cnt_r <= 8'h00;
      pg_delay_done_r <= 1'b0;
    end else if (pg_cnt_r >= ctrl_r[15:8]) begin
      pg_delay_done_r <= 1'b1;
    end else if (ms_tick) begin
      pg_cnt_r <= pg_cnt_r + 8'h01;
    end
  end

  // The pin is open collector: it is only ever driven low.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      output_good_oe <= 1'b1;
      output_good_out <= 1'b0;
    end else begin
      output_good_oe <= !(pg_delay_done_r && !pg_viol);
      output_good_out <= 1'b0;
    end
  end

  // Good only when released and the wire really reads high.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pg_good_r <= 1'b0;
    end else begin
      pg_good_r <= !output_good_oe && s_pin;
    end
  end

  // ==========================================================================
  // Fault detection
  // ==========================================================================
  logic trk_done_r;
  logic ev_oc, ev_uv, ev_ot, ev_tr, ev_ov, any_ev;
  logic running;
  assign running = (state_r == pps_pkg::PPS_RUN);

  // Tracking ends when the output goes good and stays off until a restart.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trk_done_r <= 1'b0;
    end else if (!running) begin
      trk_done_r <= 1'b0;
    end else if (pg_good_r) begin
      trk_done_r <= 1'b1;
    end
  end

  assign ev_oc = running && s_prebias && s_oc;
  assign ev_uv = running && s_steady && s_uv && !s_oc;
  assign ev_ot = s_hot;
  assign ev_tr = running && s_ramp_up && prot_r[pps_pkg::PROT_TRE] &&
                 !trk_done_r && s_trk;
  assign ev_ov = running && s_prebias && s_ov;
  assign any_ev = ev_oc || ev_uv || (running && ev_ot) || ev_tr || ev_ov;

  // Fault bits are active low; a detection wins over a software restore.
  assign hw_clear = {ev_ov, ev_tr, ev_ot, ev_uv, ev_oc, 2'b00};

  always_comb begin
    stat_nxt = stat_r;
    if (wr_en && paddr == pps_pkg::ADDR_STAT) begin
      stat_nxt[6:2] = stat_r[6:2] | pwdata[6:2];
    end
    stat_nxt[6:2] = stat_nxt[6:2] & ~hw_clear[6:2];
    stat_nxt[pps_pkg::ST_TW] = !tw_r;
    stat_nxt[pps_pkg::ST_PG] = pg_good_r;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_r <= pps_pkg::STAT_RST;
    end else begin
      stat_r <= stat_nxt;
    end
  end

  // ==========================================================================
  // Run and fault sequencing
  // ==========================================================================
  logic [4:0] cause_r;
  logic [7:0] retry_cnt_r;
  logic latched_wait, ot_hold, fast_off;
  logic [4:0] latch_cfg;

  // Cause order: ov, tr, ot, uv, oc, matching the status bits.
  assign latch_cfg = {prot_r[pps_pkg::PROT_OVC], prot_r[pps_pkg::PROT_TRC],
                      prot_r[pps_pkg::PROT_OTC], prot_r[pps_pkg::PROT_UVC],
                      prot_r[pps_pkg::PROT_OCC]};
  // A latched cause waits until software restores its status bit.
  assign latched_wait = |(cause_r & latch_cfg & ~stat_r[6:2]);
  // Overtemperature may only restart once cooled below its restart point.
  assign ot_hold = cause_r[2] && !s_cool110;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= pps_pkg::PPS_OFF;
      cause_r <= 5'h00;
      retry_cnt_r <= 8'h00;
    end else begin
      case (state_r)
        pps_pkg::PPS_OFF: begin
          retry_cnt_r <= 8'h00;
          if (ctrl_r[pps_pkg::CTRL_EN] && !s_hot) begin
            state_r <= pps_pkg::PPS_RUN;
            cause_r <= 5'h00;
          end
        end
        pps_pkg::PPS_RUN: begin
          if (any_ev) begin
            state_r <= pps_pkg::PPS_FAULT;
            cause_r <= {ev_ov, ev_tr, ev_ot, ev_uv, ev_oc};
          end else if (!ctrl_r[pps_pkg::CTRL_EN]) begin
            state_r <= pps_pkg::PPS_OFF;
          end
        end
        pps_pkg::PPS_FAULT: begin
          if (retry_cnt_r >= pps_pkg::RETRY_MS) begin
            retry_cnt_r <= 8'h00;
            if (!latched_wait && !ot_hold) begin
              state_r <= pps_pkg::PPS_OFF;
            end
          end else if (ms_tick) begin
            retry_cnt_r <= retry_cnt_r + 8'h01;
          end
        end
        default: state_r <= pps_pkg::PPS_OFF;
      endcase
    end
  end

  // Overcurrent, tracking and critical styles open the switches at once;
  // non-critical undervoltage and overtemperature hand the output to a sequenced ramp-down; overvoltage clamps the low side.
  assign fast_off = cause_r[0] || cause_r[3] ||
                    (cause_r[1] && ctrl_r[pps_pkg::CTRL_UV_CRIT]) ||
                    (cause_r[2] && ctrl_r[pps_pkg::CTRL_OT_CRIT]);

  // Switch commands; warnings never enter here, only fault causes do.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_run <= 1'b0;
      seq_rampdown <= 1'b0;
      hs_force_off <= 1'b1;
      ls_force_off <= 1'b1;
      ls_force_on <= 1'b0;
    end else begin
      pwm_run <= (state_r == pps_pkg::PPS_RUN) && !any_ev;
      if (state_r == pps_pkg::PPS_FAULT) begin
        seq_rampdown <= !fast_off && !cause_r[4];
        hs_force_off <= fast_off || cause_r[4];
        ls_force_off <= fast_off && !cause_r[4];
        ls_force_on <= cause_r[4];
      end else begin
        seq_rampdown <= 1'b0;
        hs_force_off <= (state_r == pps_pkg::PPS_OFF);
        ls_force_off <= (state_r == pps_pkg::PPS_OFF);
        ls_force_on <= 1'b0;
      end
    end
  end

endmodule

/* File: tb/pps_good_wire.sv */
// Model of the shared good wire outside the supervisor.
// Assumes a pull-up and an optional external circuit pulling low.
`timescale 1ns/1ps

module pps_good_wire (
  input wire logic oe,
  input wire logic ext_low,
  output logic lvl
);
  // =====
  // Wire level
  // The wire idles high through the pull-up when nobody pulls it.
  assign lvl = !(oe || ext_low);
endmodule

/* File: tb/pps_supervisor_assertions.sv */
// Checker for the supervisor, bound to its top-level ports.
// Assumes one clock domain and an active-low asynchronous reset.
`timescale 1ns/1ps

module pps_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  input wire logic temp_above_120,
  input wire logic temp_below_117,
  input wire logic temp_warning_flag,
  input wire logic oc_trip,
  input wire logic ov_trip,
  input wire logic vout_above_prebias,
  input wire logic pwm_run,
  input wire logic hs_force_off,
  input wire logic ls_force_off,
  input wire logic ls_force_on
);
  // =====
  // Clocking and shared sequences
  // Inputs pass a two-flop synchroniser, so windows allow for it.
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_wait;
    psel && penable && !pready;
  endsequence
  sequence s_oc;
    (oc_trip && vout_above_prebias && pwm_run) [*2];
  endsequence
  sequence s_ov;
    (ov_trip && vout_above_prebias && pwm_run) [*2];
  endsequence

  a_ready_wait: assert property ($rose(penable) && psel |-> s_wait ##1 pready)
    else $error("pready not in second access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside answer");
  a_warn_set: assert property (temp_above_120 [*5] |-> temp_warning_flag)
    else $error("temperature warning not raised");
  a_warn_hold: assert property ((!temp_below_117) [*4] ##0 temp_warning_flag
    |=> temp_warning_flag)
    else $error("temperature warning left too early");
  a_oc_off: assert property (s_oc |-> ##[1:6] (hs_force_off && ls_force_off))
    else $error("overcurrent did not open both switches");
  a_ov_clamp: assert property (s_ov |-> ##[1:6] (hs_force_off && ls_force_on))
    else $error("overvoltage did not clamp low side");
  a_ls_excl: assert property (ls_force_on |-> hs_force_off && !ls_force_off)
    else $error("low side on while high side may conduct");
endmodule

bind pps_supervisor pps_checker u_chk (.pclk, .presetn, .psel, .penable,
  .pready, .pslverr, .prdata, .temp_above_120, .temp_below_117,
  .temp_warning_flag, .oc_trip, .ov_trip, .vout_above_prebias, .pwm_run,
  .hs_force_off, .ls_force_off, .ls_force_on);

/* File: tb/pps_supervisor_test.sv */
// Self-checking bench for the supervisor, acting as APB master.
// Assumes MS_CYCLES of 10, so 130 ms of retry lasts 1300 cycles.
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_total++; \
  $display("wrong value at %0t: %h vs %h", $time, a, b); end end

module pps_supervisor_test;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic ext_low = 0, err, pready, pslverr, good_in, oe, twf, run, seq;
  logic hso, lso, lsn, tce, gout;
  logic [3:0] lim;
  logic [1:0] ovl, uvl;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] cin = 16'h0006;
  int err_total = 0, checked = 0, cyc = 0;

  // =====
  // Clock, watchdog and instances
  initial forever #20 pclk = ~pclk;
  // A hang counts as a mismatch and still reaches the verdict.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      print_verdict();
    end
  end
  pps_supervisor #(.MS_CYCLES(10)) u_dut (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .temp_above_120(cin[0]), .temp_below_117(cin[1]),
    .temp_below_110(cin[2]), .vout_above_105(cin[3]),
    .vout_above_110(cin[4]), .vout_below_90(cin[5]), .vout_below_95(cin[6]),
    .vout_above_prebias(cin[7]), .vout_steady(cin[8]),
    .vout_ramping_up(cin[9]), .vout_ramping_down(cin[10]),
    .oc_trip(cin[11]), .uv_trip(cin[12]), .ov_trip(cin[13]),
    .track_err(cin[14]), .output_good_in(good_in), .output_good_out(gout),
    .output_good_oe(oe), .temp_warning_flag(twf), .pwm_run(run),
    .seq_rampdown(seq), .hs_force_off(hso), .ls_force_off(lso),
    .ls_force_on(lsn), .oc_temp_comp_en(tce), .oc_limit_sel(lim),
    .ov_level_sel(ovl), .uv_level_sel(uvl));
  pps_good_wire u_wire (.oe(oe), .ext_low(ext_low), .lvl(good_in));

  // =====
  // Shared tasks
  task print_verdict;
    if (err_total == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task do_reset(input logic [15:0] c);
    cin <= c;
    presetn <= 0;
    repeat (6) @(posedge pclk);
    presetn <= 1;
  endtask
  // One transfer; the request holds until pready is seen at an edge.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  // =====
  // Scenarios
  task t_regs;
    logic [7:0] ad [5] = '{8'h00, 8'h04, 8'h0c, 8'h10, 8'h20};
    logic [7:0] ex [5] = '{8'h00, 8'h08, 8'h43, 8'h7e, 8'h1b};
    do_reset(16'h0006);
    foreach (ad[i]) begin
      apb(0, ad[i], 0);
      `CHK(rd, {24'h0, ex[i]})
    end
    apb(0, 8'h08, 0);
    `CHK({err, rd}, 33'h1_0000_0000)
    apb(1, 8'h04, 32'h3f);
    apb(0, 8'h04, 0);
    `CHK(rd, 32'h3f)
    `CHK(tce, 1'b1)
    apb(1, 8'h20, 32'h0f);
    @(posedge pclk);
    `CHK({tce, lim}, 5'h0b)
    apb(0, 8'h14, 0);
    `CHK(rd, 32'h80)
  endtask
  task t_warn;
    do_reset(16'h0006);
    cin[0] <= 1;
    repeat (6) @(posedge pclk);
    `CHK(twf, 1'b1)
    apb(0, 8'h10, 0);
    `CHK(rd[1], 1'b0)
    cin[1:0] <= 2'b00;
    repeat (6) @(posedge pclk);
    `CHK(twf, 1'b1)
    cin[1] <= 1;
    repeat (6) @(posedge pclk);
    `CHK(twf, 1'b0)
  endtask
  task t_good;
    do_reset(16'h0186);
    apb(1, 8'h00, 32'h1);
    repeat (10) @(posedge pclk);
    `CHK({run, oe, gout}, 3'b100)
    apb(1, 8'h04, 32'h30);
    apb(0, 8'h04, 0);
    `CHK(rd, 32'h08)
    cin[6] <= 1;
    cin[3] <= 1;
    repeat (6) @(posedge pclk);
    `CHK(oe, 1'b0)
    cin[5] <= 1;
    repeat (6) @(posedge pclk);
    `CHK({run, oe}, 2'b11)
    apb(0, 8'h10, 0);
    `CHK(rd[0], 1'b0)
    cin[5] <= 0;
    repeat (6) @(posedge pclk);
    apb(0, 8'h10, 0);
    `CHK({oe, rd[0]}, 2'b01)
    ext_low <= 1;
    repeat (6) @(posedge pclk);
    apb(0, 8'h10, 0);
    `CHK({run, rd[0]}, 2'b10)
    ext_low <= 0;
    apb(1, 8'h00, 32'h2);
    repeat (6) @(posedge pclk);
    `CHK({run, oe}, 2'b00)
    cin[10] <= 1;
    repeat (6) @(posedge pclk);
    `CHK(oe, 1'b1)
  endtask
  // Tighter window selections: 105 percent high and 95 percent low.
  task t_window;
    do_reset(16'h018e);
    apb(1, 8'h04, 32'h38);
    apb(1, 8'h00, 32'h1);
    repeat (10) @(posedge pclk);
    `CHK({run, oe}, 2'b11)
    `CHK({ovl, uvl}, 4'b1000)
    cin[3] <= 0;
    repeat (6) @(posedge pclk);
    `CHK(oe, 1'b0)
    cin[6] <= 1;
    repeat (6) @(posedge pclk);
    `CHK(oe, 1'b1)
  endtask
  // Raise one trip input in run and judge switches and status.
  task t_fault(input logic [31:0] ct, input logic [31:0] pr,
               input logic [15:0] base, input int idx,
               input logic [4:0] ex, input int sb, input logic sv);
    do_reset(base);
    apb(1, 8'h0c, pr);
    apb(1, 8'h00, ct);
    repeat (8) @(posedge pclk);
    cin[idx] <= 1;
    repeat (8) @(posedge pclk);
    `CHK({hso, lso, lsn, seq, run}, ex)
    apb(0, 8'h10, 0);
    `CHK(rd[sb], sv)
  endtask
  task t_retry;
    do_reset(16'h0186);
    apb(1, 8'h00, 32'h1);
    repeat (8) @(posedge pclk);
    cin[11] <= 1;
    for (int i = 0; i < 20 && run !== 1'b0; i++) @(posedge pclk);
    cin[11] <= 0;
    repeat (1270) @(posedge pclk);
    `CHK(run, 1'b0)
    for (int i = 0; i < 100 && run !== 1'b1; i++) @(posedge pclk);
    `CHK(run, 1'b1)
    apb(1, 8'h00, 32'h0);
    repeat (6) @(posedge pclk);
    `CHK({run, oe}, 2'b01)
  endtask

  // =====
  // Main sequence
  initial begin
    t_regs;
    t_warn;
    t_good;
    t_window;
    t_fault(1, 8'h43, 16'h0186, 11, 5'b11000, 2, 0);
    t_fault(1, 8'h43, 16'h0186, 13, 5'b10100, 6, 0);
    t_fault(1, 8'h43, 16'h0186, 12, 5'b00010, 3, 0);
    t_fault(5, 8'h43, 16'h0186, 12, 5'b11000, 3, 0);
    t_fault(1, 8'h43, 16'h0186, 0, 5'b00010, 4, 0);
    t_fault(9, 8'h43, 16'h0186, 0, 5'b11000, 4, 0);
    t_fault(1, 8'hc3, 16'h0286, 14, 5'b11000, 5, 0);
    t_fault(1, 8'h43, 16'h0286, 14, 5'b00001, 5, 1);
    t_retry;
    print_verdict;
  end
endmodule
